/* src/sbe_pkg.sv */
// constants, field positions and carrier types for the serial buffer and irq enable slice
// assumes a single system clock and a same-clock special function register bus
package sbe_pkg;

	// =====================================================================
	// register addresses and reset values
	localparam logic [7:0] SBE_ADDR_UART0_DATA = 8'h99;
	localparam logic [7:0] SBE_ADDR_UART1_DATA = 8'h9A;
	localparam logic [7:0] SBE_ADDR_IRQ_EN = 8'h9B;
	localparam logic [7:0] SBE_RST_UART0_DATA = 8'h00;
	localparam logic [7:0] SBE_RST_UART1_DATA = 8'h00;
	localparam logic [7:0] SBE_RST_IRQ_EN = 8'h00;
	localparam logic [7:0] SBE_UNMAPPED_RDATA = 8'h00;

	// =====================================================================
	// bit positions of extended_irq_enables and of the request vector
	localparam int SBE_BIT_TIMER2 = 7;
	localparam int SBE_BIT_SPI = 6;
	localparam int SBE_BIT_BRAKE = 5;
	localparam int SBE_BIT_WATCHDOG = 4;
	localparam int SBE_BIT_PWM = 3;
	localparam int SBE_BIT_CAPTURE = 2;
	localparam int SBE_BIT_PIN = 1;
	localparam int SBE_BIT_I2C = 0;

	// =====================================================================
	// sizes and timing
	localparam int SBE_DATA_W = 8;
	localparam int SBE_FIFO_DEPTH = 8;
	localparam int SBE_BIT_CYCLES = 16;
	localparam int SBE_FRAME_BITS = 8;

	// =====================================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sbe_sfr_req_s;

	typedef struct packed {
		logic timer2_overflow_flag;
		logic spi_done_flag;
		logic spi_overrun_flag;
		logic spi_mode_fault_flag;
		logic brake_event_flag;
		logic watchdog_timeout_flag;
		logic pwm_period_flag;
		logic [2:0] capture_channel_flags;
		logic [7:0] pin_event_flags;
		logic i2c_state_flag;
		logic i2c_timeout_flag;
	} sbe_irq_src_s;

	typedef enum {
		SBE_TX_IDLE,
		SBE_TX_START,
		SBE_TX_DATA,
		SBE_TX_STOP
	} sbe_tx_state_e;

endpackage

/* src/sbe_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
// assumes both sides on the same clock; full refuses, empty withholds valid
`timescale 1ns/100ps

module sbe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input logic clk, // system clock
	input logic rst, // synchronous reset, active high
	input logic wr_valid, // word offered
	input logic [WIDTH-1:0] wr_data, // word to store
	output logic wr_ready, // room for a word
	output logic rd_valid, // word available
	output logic [WIDTH-1:0] rd_data, // oldest word
	input logic rd_ready // consumer takes the word
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// =====================================================================
	// pointers and fill level
	always_comb begin
		push = wr_valid && wr_ready;
		pop = rd_valid && rd_ready;
		wp_nxt = push ? wrap_inc(wp_r) : wp_r;
		rp_nxt = pop ? wrap_inc(rp_r) : rp_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage is not reset; nothing reads an empty slot
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= wr_data;
		end
	end

	assign wr_ready = (cnt_r != CW'(DEPTH));
	assign rd_valid = (cnt_r != '0);
	assign rd_data = mem[rp_r];

endmodule

/* src/sbe_tx_shift.sv */
// serial transmit shifter: start bit, eight data bits lsb first, stop bit
// assumes the byte source holds valid until in_ready takes it
`timescale 1ns/100ps

module sbe_tx_shift #(
	parameter int BIT_CYCLES = sbe_pkg::SBE_BIT_CYCLES
) (
	input logic clk, // system clock
	input logic rst, // synchronous reset, active high
	input logic in_valid, // byte offered
	input logic [7:0] in_data, // byte to send
	output logic in_ready, // idle, takes the byte
	output logic txd, // serial line, idles high
	output logic done // one-cycle pulse at end of stop bit
);

	sbe_pkg::sbe_tx_state_e state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [2:0] bitn_r, bitn_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic txd_r, txd_nxt, done_r, done_nxt;
	logic bit_end;

	// =====================================================================
	// frame sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		bitn_nxt = bitn_r;
		sh_nxt = sh_r;
		txd_nxt = txd_r;
		done_nxt = 1'b0;
		bit_end = (cnt_r == 16'(BIT_CYCLES - 1));
		if (state_r != sbe_pkg::SBE_TX_IDLE) begin
			cnt_nxt = bit_end ? '0 : cnt_r + 1'b1;
		end
		unique case (state_r)
			sbe_pkg::SBE_TX_IDLE: begin
				txd_nxt = 1'b1;
				if (in_valid) begin
					sh_nxt = in_data;
					cnt_nxt = '0;
					txd_nxt = 1'b0;
					state_nxt = sbe_pkg::SBE_TX_START;
				end
			end
			sbe_pkg::SBE_TX_START: begin
				if (bit_end) begin
					bitn_nxt = '0;
					txd_nxt = sh_r[0];
					state_nxt = sbe_pkg::SBE_TX_DATA;
				end
			end
			sbe_pkg::SBE_TX_DATA: begin
				if (bit_end) begin
					if (bitn_r == 3'(sbe_pkg::SBE_FRAME_BITS - 1)) begin
						txd_nxt = 1'b1;
						state_nxt = sbe_pkg::SBE_TX_STOP;
					end else begin
						bitn_nxt = bitn_r + 1'b1;
						sh_nxt = {1'b0, sh_r[7:1]};
						txd_nxt = sh_r[1];
					end
				end
			end
			sbe_pkg::SBE_TX_STOP: begin
				if (bit_end) begin
					done_nxt = 1'b1;
					state_nxt = sbe_pkg::SBE_TX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= sbe_pkg::SBE_TX_IDLE;
			cnt_r <= '0;
			bitn_r <= '0;
			sh_r <= '0;
			txd_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			bitn_r <= bitn_nxt;
			sh_r <= sh_nxt;
			txd_r <= txd_nxt;
			done_r <= done_nxt;
		end
	end

	assign in_ready = (state_r == sbe_pkg::SBE_TX_IDLE);
	assign txd = txd_r;
	assign done = done_r;

endmodule

/* src/sbe_regs.sv */
// serial data buffers of two ports and the extended interrupt enable register
// assumes the register bus, receive engines and peripheral flags share REF_CLK
`timescale 1ns/100ps

module sbe_regs #(
	parameter int BIT_CYCLES = sbe_pkg::SBE_BIT_CYCLES,
	parameter int FIFO_DEPTH = sbe_pkg::SBE_FIFO_DEPTH
) (
	input logic REF_CLK, // system clock
	input logic RESET, // synchronous reset, active high
	input sbe_pkg::sbe_sfr_req_s SFR_REQ, // register bus request
	output logic [7:0] SFR_RDATA, // read data, one cycle after rd
	input logic UART0_RX_VALID, // port 0 receiver has a byte
	input logic [7:0] UART0_RX_DATA, // port 0 received byte
	input logic UART1_RX_VALID, // port 1 receiver has a byte
	input logic [7:0] UART1_RX_DATA, // port 1 received byte
	output logic UART0_TXD, // port 0 serial output
	output logic UART0_TX_READY, // port 0 buffer has room
	output logic UART1_TX_START, // port 1 start pulse
	output logic [7:0] UART1_TX_DATA, // port 1 byte to shift
	output logic UART0_TX_DONE_FLAG, // port 0 transmit done flag
	input logic UART0_TX_DONE_CLR, // software clear of done flag
	input logic SERIAL0_IRQ_ALLOW, // serial port 0 interrupt enable
	output logic SERIAL0_IRQ, // serial port 0 request
	input sbe_pkg::sbe_irq_src_s IRQ_SRC, // peripheral flags
	output logic [7:0] IRQ_REQ // gated requests to the core
);

	logic wr0, wr1, wr_en, rd_any;
	logic fifo_wr_ready, fifo_rd_valid, fifo_rd_ready, tx0_done;
	logic [7:0] fifo_rd_data;
	logic [7:0] allow_r, allow_nxt;
	logic [7:0] rx0_r, rx0_nxt, rx1_r, rx1_nxt;
	logic [7:0] tx1_data_r, tx1_data_nxt;
	logic tx1_start_r, tx1_start_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic done_r, done_nxt;
	logic serial_r, serial_nxt;
	logic [7:0] irq_r, irq_nxt;
	logic [7:0] src_vec;

	function automatic logic sfr_hit(input logic stb, input logic [7:0] a, input logic [7:0] target);
		return stb && (a == target);
	endfunction

	// =====================================================================
	// address decode
	always_comb begin
		wr0 = sfr_hit(SFR_REQ.wr, SFR_REQ.addr, sbe_pkg::SBE_ADDR_UART0_DATA);
		wr1 = sfr_hit(SFR_REQ.wr, SFR_REQ.addr, sbe_pkg::SBE_ADDR_UART1_DATA);
		wr_en = sfr_hit(SFR_REQ.wr, SFR_REQ.addr, sbe_pkg::SBE_ADDR_IRQ_EN);
		rd_any = SFR_REQ.rd;
	end

	// =====================================================================
	// port 0 transmit path: buffer then shifter
	// a write while the buffer is full is dropped; software polls UART0_TX_READY
	sbe_fifo #(
		.WIDTH(sbe_pkg::SBE_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx0_fifo (
		.clk(REF_CLK),
		.rst(RESET),
		.wr_valid(wr0),
		.wr_data(SFR_REQ.wdata),
		.wr_ready(fifo_wr_ready),
		.rd_valid(fifo_rd_valid),
		.rd_data(fifo_rd_data),
		.rd_ready(fifo_rd_ready)
	);

	sbe_tx_shift #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx0_shift (
		.clk(REF_CLK),
		.rst(RESET),
		.in_valid(fifo_rd_valid),
		.in_data(fifo_rd_data),
		.in_ready(fifo_rd_ready),
		.txd(UART0_TXD),
		.done(tx0_done)
	);

	assign UART0_TX_READY = fifo_wr_ready;

	// =====================================================================
	// flag vector in enable-bit order
	always_comb begin
		src_vec = '0;
		src_vec[sbe_pkg::SBE_BIT_TIMER2] = IRQ_SRC.timer2_overflow_flag;
		src_vec[sbe_pkg::SBE_BIT_SPI] = IRQ_SRC.spi_done_flag | IRQ_SRC.spi_overrun_flag |
			IRQ_SRC.spi_mode_fault_flag;
		src_vec[sbe_pkg::SBE_BIT_BRAKE] = IRQ_SRC.brake_event_flag;
		src_vec[sbe_pkg::SBE_BIT_WATCHDOG] = IRQ_SRC.watchdog_timeout_flag;
		src_vec[sbe_pkg::SBE_BIT_PWM] = IRQ_SRC.pwm_period_flag;
		src_vec[sbe_pkg::SBE_BIT_CAPTURE] = |IRQ_SRC.capture_channel_flags;
		src_vec[sbe_pkg::SBE_BIT_PIN] = |IRQ_SRC.pin_event_flags;
		src_vec[sbe_pkg::SBE_BIT_I2C] = IRQ_SRC.i2c_state_flag | IRQ_SRC.i2c_timeout_flag;
	end

	// =====================================================================
	// register file and request gating
	always_comb begin
		allow_nxt = allow_r;
		rx0_nxt = rx0_r;
		rx1_nxt = rx1_r;
		tx1_data_nxt = tx1_data_r;
		tx1_start_nxt = 1'b0;
		rdata_nxt = rdata_r;
		if (wr_en) begin
			allow_nxt = SFR_REQ.wdata;
		end
		if (wr1) begin
			tx1_data_nxt = SFR_REQ.wdata;
			tx1_start_nxt = 1'b1;
		end
		if (UART0_RX_VALID) begin
			rx0_nxt = UART0_RX_DATA;
		end
		if (UART1_RX_VALID) begin
			rx1_nxt = UART1_RX_DATA;
		end
		if (rd_any) begin
			unique case (SFR_REQ.addr)
				sbe_pkg::SBE_ADDR_UART0_DATA: rdata_nxt = rx0_r;
				sbe_pkg::SBE_ADDR_UART1_DATA: rdata_nxt = rx1_r;
				sbe_pkg::SBE_ADDR_IRQ_EN: rdata_nxt = allow_r;
				default: rdata_nxt = sbe_pkg::SBE_UNMAPPED_RDATA;
			endcase
		end
		// set wins over a clear in the same cycle
		done_nxt = tx0_done ? 1'b1 : (UART0_TX_DONE_CLR ? 1'b0 : done_r);
		serial_nxt = done_nxt && SERIAL0_IRQ_ALLOW;
		// flags pass through untouched; only the request is masked
		irq_nxt = allow_r & src_vec;
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			allow_r <= sbe_pkg::SBE_RST_IRQ_EN;
			rx0_r <= sbe_pkg::SBE_RST_UART0_DATA;
			rx1_r <= sbe_pkg::SBE_RST_UART1_DATA;
			tx1_data_r <= sbe_pkg::SBE_RST_UART1_DATA;
			tx1_start_r <= 1'b0;
			rdata_r <= sbe_pkg::SBE_UNMAPPED_RDATA;
			done_r <= 1'b0;
			serial_r <= 1'b0;
			irq_r <= '0;
		end else begin
			allow_r <= allow_nxt;
			rx0_r <= rx0_nxt;
			rx1_r <= rx1_nxt;
			tx1_data_r <= tx1_data_nxt;
			tx1_start_r <= tx1_start_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
			serial_r <= serial_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign SFR_RDATA = rdata_r;
	assign UART1_TX_START = tx1_start_r;
	assign UART1_TX_DATA = tx1_data_r;
	assign UART0_TX_DONE_FLAG = done_r;
	assign SERIAL0_IRQ = serial_r;
	assign IRQ_REQ = irq_r;

	// =====================================================================
	// checks
	tx0_launch_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		wr0 && !fifo_rd_valid && fifo_rd_ready |=> ##[0:2] !UART0_TXD)
		else $error("port 0 write did not start a frame");

	rx0_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		SFR_REQ.rd && SFR_REQ.addr == sbe_pkg::SBE_ADDR_UART0_DATA |=> SFR_RDATA == $past(rx0_r))
		else $error("port 0 read did not return receive register");

	rx1_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		SFR_REQ.rd && SFR_REQ.addr == sbe_pkg::SBE_ADDR_UART1_DATA |=> SFR_RDATA == $past(rx1_r))
		else $error("port 1 read did not return receive register");

	tx1_start_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		wr1 |=> UART1_TX_START && UART1_TX_DATA == $past(SFR_REQ.wdata) ##1 (!UART1_TX_START || $past(wr1)))
		else $error("port 1 write did not pulse start with the byte");

	timer_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		1'b1 |=> IRQ_REQ[7] == ($past(allow_r[7]) && $past(IRQ_SRC.timer2_overflow_flag)))
		else $error("timer 2 request gating wrong");

	spi_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[6] && IRQ_SRC.spi_mode_fault_flag |=> IRQ_REQ[6])
		else $error("spi mode fault not forwarded");

	capture_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[2] && IRQ_SRC.capture_channel_flags[2] |=> IRQ_REQ[2])
		else $error("capture channel 2 not forwarded");

	pin_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!allow_r[1] |=> !IRQ_REQ[1])
		else $error("pin request passed while disabled");

	i2c_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[0] && IRQ_SRC.i2c_timeout_flag |=> IRQ_REQ[0])
		else $error("i2c timeout not forwarded");

	done_set_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		tx0_done |=> UART0_TX_DONE_FLAG ##1 (UART0_TX_DONE_FLAG || $past(UART0_TX_DONE_CLR)))
		else $error("done flag not set or lost");

	mask_only_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		wr_en && SFR_REQ.wdata == 8'h00 |=> ##1 IRQ_REQ == 8'h00)
		else $error("request survived clearing all enables");

	brake_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		1'b1 |=> IRQ_REQ[sbe_pkg::SBE_BIT_BRAKE] ==
			($past(allow_r[sbe_pkg::SBE_BIT_BRAKE]) && $past(IRQ_SRC.brake_event_flag)))
		else $error("brake request gating wrong");

	wdog_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		1'b1 |=> IRQ_REQ[sbe_pkg::SBE_BIT_WATCHDOG] ==
			($past(allow_r[sbe_pkg::SBE_BIT_WATCHDOG]) && $past(IRQ_SRC.watchdog_timeout_flag)))
		else $error("watchdog request gating wrong");

	pwm_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		1'b1 |=> IRQ_REQ[sbe_pkg::SBE_BIT_PWM] ==
			($past(allow_r[sbe_pkg::SBE_BIT_PWM]) && $past(IRQ_SRC.pwm_period_flag)))
		else $error("pwm request gating wrong");

	spi_done_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[sbe_pkg::SBE_BIT_SPI] && IRQ_SRC.spi_done_flag |=> IRQ_REQ[sbe_pkg::SBE_BIT_SPI])
		else $error("spi transfer done not forwarded");

	spi_overrun_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[sbe_pkg::SBE_BIT_SPI] && IRQ_SRC.spi_overrun_flag |=> IRQ_REQ[sbe_pkg::SBE_BIT_SPI])
		else $error("spi overrun not forwarded");

	spi_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!allow_r[sbe_pkg::SBE_BIT_SPI] |=> !IRQ_REQ[sbe_pkg::SBE_BIT_SPI])
		else $error("spi request passed while disabled");

	capture_chan0_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[sbe_pkg::SBE_BIT_CAPTURE] && IRQ_SRC.capture_channel_flags[0] |=> IRQ_REQ[sbe_pkg::SBE_BIT_CAPTURE])
		else $error("capture channel 0 not forwarded");

	capture_none_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		IRQ_SRC.capture_channel_flags == 3'h0 |=> !IRQ_REQ[sbe_pkg::SBE_BIT_CAPTURE])
		else $error("capture request without a flag");

	pin_any_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[sbe_pkg::SBE_BIT_PIN] && IRQ_SRC.pin_event_flags != 8'h00 |=> IRQ_REQ[sbe_pkg::SBE_BIT_PIN])
		else $error("pin event not forwarded");

	pin_none_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		IRQ_SRC.pin_event_flags == 8'h00 |=> !IRQ_REQ[sbe_pkg::SBE_BIT_PIN])
		else $error("pin request without a flag");

	i2c_state_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		allow_r[sbe_pkg::SBE_BIT_I2C] && IRQ_SRC.i2c_state_flag |=> IRQ_REQ[sbe_pkg::SBE_BIT_I2C])
		else $error("i2c state change not forwarded");

	i2c_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!allow_r[sbe_pkg::SBE_BIT_I2C] |=> !IRQ_REQ[sbe_pkg::SBE_BIT_I2C])
		else $error("i2c request passed while disabled");

	en_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		wr_en |=> allow_r == $past(SFR_REQ.wdata))
		else $error("enable register write lost");

	en_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		SFR_REQ.rd && SFR_REQ.addr == sbe_pkg::SBE_ADDR_IRQ_EN |=> SFR_RDATA == $past(allow_r))
		else $error("enable register read wrong");

	rx0_load_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		UART0_RX_VALID |=> rx0_r == $past(UART0_RX_DATA))
		else $error("port 0 receive byte not stored");

	rx1_load_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		UART1_RX_VALID |=> rx1_r == $past(UART1_RX_DATA))
		else $error("port 1 receive byte not stored");

	txd_idle_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!fifo_rd_valid && fifo_rd_ready |=> UART0_TXD)
		else $error("port 0 line left idle level without a byte");

	done_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		UART0_TX_DONE_FLAG && !UART0_TX_DONE_CLR |=> UART0_TX_DONE_FLAG)
		else $error("done flag dropped without a clear");

	done_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		UART0_TX_DONE_CLR && !tx0_done |=> !UART0_TX_DONE_FLAG)
		else $error("done flag survived a clear");

	serial_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!SERIAL0_IRQ_ALLOW |=> !SERIAL0_IRQ)
		else $error("serial request passed while disabled");

	tx1_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!wr1 |=> !UART1_TX_START && $stable(UART1_TX_DATA))
		else $error("port 1 start or byte changed without a write");

	rdata_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		!SFR_REQ.rd |=> $stable(SFR_RDATA))
		else $error("read data changed without a read");

endmodule

/* testbench/sbe_line_rx.sv */
// listener on the port 0 serial line, standing in for the far end
// assumes 8N1 frames, BIT_CYCLES clocks per bit, line idling high
`timescale 1ns/100ps

module sbe_line_rx #(
	parameter int BIT_CYCLES = 4
) (
	input wire logic clk, // system clock
	input wire logic line, // serial line from the block
	output logic got, // pulse per decoded frame
	output logic [7:0] data, // decoded byte
	output logic stop_ok // last stop bit was high
);
	// =====================================
	// frame decoder, samples mid-bit to stay clear of the edges
	initial begin
		got = 1'b0;
		data = 8'h00;
		stop_ok = 1'b1;
		forever begin
			@(negedge line);
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				#1 data[i] = line;
			end
			repeat (BIT_CYCLES) @(posedge clk);
			#1 stop_ok = line;
			got = 1'b1;
			@(posedge clk);
			#1 got = 1'b0;
		end
	end
endmodule

/* testbench/serial_buffer_irq_enable_regs_tb.sv */
// self-checking bench for the serial buffers and extended irq enables
// assumes sbe_pkg and the design files are compiled first
`timescale 1ns/100ps

module serial_buffer_irq_enable_regs_tb;
	localparam int BITC = 4;
	logic REF_CLK = 1'b0;
	logic RESET = 1'b1;
	sbe_pkg::sbe_sfr_req_s SFR_REQ = '0;
	sbe_pkg::sbe_irq_src_s IRQ_SRC = '0;
	logic [7:0] SFR_RDATA, UART1_TX_DATA, IRQ_REQ, rx_data;
	logic UART0_RX_VALID = 1'b0, UART1_RX_VALID = 1'b0, UART0_TX_DONE_CLR = 1'b0, SERIAL0_IRQ_ALLOW = 1'b0;
	logic [7:0] UART0_RX_DATA = 8'h00, UART1_RX_DATA = 8'h00;
	logic UART0_TXD, UART0_TX_READY, UART1_TX_START, UART0_TX_DONE_FLAG, SERIAL0_IRQ, got, stop_ok;
	int failures = 0, samples_checked = 0, accepted;
	logic [7:0] exp_q[$];

	// =====================================
	// design and far end
	sbe_regs #(.BIT_CYCLES(BITC), .FIFO_DEPTH(sbe_pkg::SBE_FIFO_DEPTH)) dut (.REF_CLK(REF_CLK), .RESET(RESET),
		.SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .UART0_RX_VALID(UART0_RX_VALID), .UART0_RX_DATA(UART0_RX_DATA),
		.UART1_RX_VALID(UART1_RX_VALID), .UART1_RX_DATA(UART1_RX_DATA), .UART0_TXD(UART0_TXD),
		.UART0_TX_READY(UART0_TX_READY), .UART1_TX_START(UART1_TX_START), .UART1_TX_DATA(UART1_TX_DATA),
		.UART0_TX_DONE_FLAG(UART0_TX_DONE_FLAG), .UART0_TX_DONE_CLR(UART0_TX_DONE_CLR),
		.SERIAL0_IRQ_ALLOW(SERIAL0_IRQ_ALLOW), .SERIAL0_IRQ(SERIAL0_IRQ), .IRQ_SRC(IRQ_SRC), .IRQ_REQ(IRQ_REQ));
	sbe_line_rx #(.BIT_CYCLES(BITC)) far_end (.clk(REF_CLK), .line(UART0_TXD), .got(got), .data(rx_data),
		.stop_ok(stop_ok));

	initial begin
		forever #5 REF_CLK = ~REF_CLK;
	end

	// =====================================
	// shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		SFR_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge REF_CLK);
		SFR_REQ <= '0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge REF_CLK);
		SFR_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge REF_CLK);
		SFR_REQ <= '0;
		#1 check(what, SFR_RDATA, exp);
	endtask

	task automatic wait_drained;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 3000) begin
			@(posedge REF_CLK);
			n++;
		end
		if (n >= 3000) begin
			failures++;
			test_done();
		end
	endtask

	// request bit expected for one source bit of the packed flags, msb first
	function automatic logic [7:0] req_of(input int k);
		return k == 19 ? 8'h80 : k >= 16 ? 8'h40 : k == 15 ? 8'h20 : k == 14 ? 8'h10 : k == 13 ? 8'h08 :
			k >= 10 ? 8'h04 : k >= 2 ? 8'h02 : 8'h01;
	endfunction

	// every decoded frame must match the oldest accepted byte
	always @(posedge got) begin
		if (exp_q.size() == 0) begin
			check("unexpected_frame", 8'h00, 8'h01);
		end else begin
			check("tx_byte", rx_data, exp_q.pop_front());
		end
		check("stop_bit", {7'h00, stop_ok}, 8'h01);
	end

	// =====================================
	// main sequence
	initial begin
		repeat (12) @(posedge REF_CLK);
		RESET <= 1'b0;
		rd_chk("uart0_rst", sbe_pkg::SBE_ADDR_UART0_DATA, sbe_pkg::SBE_RST_UART0_DATA);
		rd_chk("uart1_rst", sbe_pkg::SBE_ADDR_UART1_DATA, sbe_pkg::SBE_RST_UART1_DATA);
		rd_chk("irq_en_rst", sbe_pkg::SBE_ADDR_IRQ_EN, sbe_pkg::SBE_RST_IRQ_EN);
		sfr_wr(8'h55, 8'hFF);
		rd_chk("unmapped", 8'h55, sbe_pkg::SBE_UNMAPPED_RDATA);
		rd_chk("irq_en_kept", sbe_pkg::SBE_ADDR_IRQ_EN, 8'h00);
		sfr_wr(sbe_pkg::SBE_ADDR_IRQ_EN, 8'hA5);
		rd_chk("irq_en_rw", sbe_pkg::SBE_ADDR_IRQ_EN, 8'hA5);
		// each flag alone, once with all enables and once with all others
		for (int k = 0; k < 20; k++) begin
			@(posedge REF_CLK);
			IRQ_SRC <= sbe_pkg::sbe_irq_src_s'(20'h0_0001 << k);
			sfr_wr(sbe_pkg::SBE_ADDR_IRQ_EN, 8'hFF);
			@(posedge REF_CLK);
			#1 check("irq_req_on", IRQ_REQ, req_of(k));
			sfr_wr(sbe_pkg::SBE_ADDR_IRQ_EN, ~req_of(k));
			@(posedge REF_CLK);
			#1 check("irq_req_off", IRQ_REQ, 8'h00);
		end
		// every flag raised, then all enables cleared at once
		@(posedge REF_CLK);
		IRQ_SRC <= '1;
		sfr_wr(sbe_pkg::SBE_ADDR_IRQ_EN, 8'hFF);
		@(posedge REF_CLK);
		#1 check("irq_req_all", IRQ_REQ, 8'hFF);
		sfr_wr(sbe_pkg::SBE_ADDR_IRQ_EN, 8'h00);
		@(posedge REF_CLK);
		#1 check("irq_req_none", IRQ_REQ, 8'h00);
		// receive side stays apart from the transmit side
		@(posedge REF_CLK);
		IRQ_SRC <= '0;
		UART0_RX_VALID <= 1'b1;
		UART0_RX_DATA <= 8'h5A;
		UART1_RX_VALID <= 1'b1;
		UART1_RX_DATA <= 8'h96;
		@(posedge REF_CLK);
		UART0_RX_VALID <= 1'b0;
		UART1_RX_VALID <= 1'b0;
		exp_q.push_back(8'hC3);
		sfr_wr(sbe_pkg::SBE_ADDR_UART0_DATA, 8'hC3);
		rd_chk("uart0_rx", sbe_pkg::SBE_ADDR_UART0_DATA, 8'h5A);
		sfr_wr(sbe_pkg::SBE_ADDR_UART1_DATA, 8'h69);
		#1 check("uart1_start", {7'h00, UART1_TX_START}, 8'h01);
		check("uart1_data", UART1_TX_DATA, 8'h69);
		@(posedge REF_CLK);
		#1 check("uart1_start_end", {7'h00, UART1_TX_START}, 8'h00);
		rd_chk("uart1_rx", sbe_pkg::SBE_ADDR_UART1_DATA, 8'h96);
		wait_drained();
		// fill port 0 buffer until refused, then one dropped write
		SERIAL0_IRQ_ALLOW <= 1'b1;
		accepted = 0;
		while (accepted < 20) begin
			#1;
			if (UART0_TX_READY !== 1'b1) begin
				break;
			end
			exp_q.push_back(8'h11 * accepted[7:0]);
			sfr_wr(sbe_pkg::SBE_ADDR_UART0_DATA, 8'h11 * accepted[7:0]);
			accepted++;
		end
		check("fill_count", 8'(accepted), 8'(sbe_pkg::SBE_FIFO_DEPTH + 1));
		sfr_wr(sbe_pkg::SBE_ADDR_UART0_DATA, 8'hEE);
		wait_drained();
		// long enough for a wrongly taken extra byte to reach the listener
		repeat (12 * BITC) @(posedge REF_CLK);
		#1 check("done_flag", {7'h00, UART0_TX_DONE_FLAG}, 8'h01);
		check("serial0_irq", {7'h00, SERIAL0_IRQ}, 8'h01);
		@(posedge REF_CLK);
		UART0_TX_DONE_CLR <= 1'b1;
		@(posedge REF_CLK);
		UART0_TX_DONE_CLR <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		#1 check("done_clear", {7'h00, UART0_TX_DONE_FLAG}, 8'h00);
		check("serial0_irq_clear", {7'h00, SERIAL0_IRQ}, 8'h00);
		test_done();
	end
endmodule
